// ===== pkg/cct_consts.vh
`ifndef CCT_CONSTS_VH
`define CCT_CONSTS_VH
// ----------------------------------------
// Register indices (8-bit registers)
// ----------------------------------------
`define CCT_A_CNT_LO     4'h0
`define CCT_A_PRE        4'h1
`define CCT_B_CNT_LO     4'h2
`define CCT_B_PRE        4'h3
`define CCT_MODE         4'h4
`define CCT_A_CNT_HI     4'h8
`define CCT_C_MODE       4'h9
`define CCT_B_CNT_HI     4'hA
`define CCT_C_PRE        4'hB
`define CCT_C_CAP_HI     4'hC
`define CCT_C_CAP_LO     4'hD
`define CCT_C_CNT_HI     4'hE
`define CCT_C_CNT_LO     4'hF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCT_LOAD_BIT     0
`define CCT_RUN_BIT      1
`define CCT_CONT_BIT     2
`define CCT_OUTEN_BIT    3
`define CCT_SLOW_BIT     4
`define CCT_EOC_BIT      7
// ----------------------------------------
// Cascade select codes
// ----------------------------------------
`define CCT_CAS_32       2'h0
`define CCT_CAS_16       2'h1
`define CCT_CAS_B24      2'h2
`define CCT_CAS_C24      2'h3
// ----------------------------------------
// Reset values and divider counts
// ----------------------------------------
`define CCT_MODE_RST     8'h00
`define CCT_CPRE_RST     8'h00
`define CCT_DIV_FAST     4'h0
`define CCT_DIV_SLOW     4'h3
`endif

// ===== verilog/cct_chan.v
`timescale 1ns/100ps
`include "cct_consts.vh"
// ----------------------------------------
// One down-counter channel with prescaler
// ----------------------------------------
module cct_chan (
  input  wire        clk,
  input  wire        reset,
  input  wire        tick,
  input  wire [5:0]  pre_div,
  input  wire        run,
  input  wire        cont,
  input  wire        load,
  input  wire [31:0] reload,
  input  wire [31:0] len_mask,
  output reg  [31:0] count_q,
  output reg         eoc_q
);
  reg [5:0] pre_q;
  reg       stop_q;
  wire      step = run & tick & ~stop_q & (pre_q == 6'h00);
  // Prescaler and counter; single pass parks at zero until reload
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q   <= 6'h00;
      stop_q  <= 1'b0;
      count_q <= 32'h0000_0000;
      eoc_q   <= 1'b0;
    end else begin
      eoc_q <= 1'b0;
      if (load) begin
        pre_q   <= pre_div;
        stop_q  <= 1'b0;
        count_q <= reload & len_mask;
      end else if (run & tick) begin
        pre_q <= (pre_q == 6'h00) ? pre_div : pre_q - 6'h01;
        if (step) begin
          if ((count_q & len_mask) == 32'h0000_0000) begin
            eoc_q   <= 1'b1;
            // Count mode looked at only here
            if (cont)
              count_q <= reload & len_mask; // RQ10
            else
              stop_q <= 1'b1; // RQ10
          end else begin
            count_q <= (count_q - 32'h0000_0001) & len_mask;
          end
        end
      end
    end
  end
endmodule // cct_chan

// ===== verilog/cct_top.v
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "cct_consts.vh"
// How it works
// [RQ1] Timer C works like timer A otherwise
// [RQ2] Output enable routes timer C to pin
// [RQ3] Timer C request ORed with edge pin
// [RQ4] End-of-count bit 7 set, software clears
// [RQ5] Reset: A,B 8-bit, C 32-bit, off
// [RQ6] Software keeps A 8-bit for serial
// [RQ7] A counts low, or high plus low
// [RQ8] B 8, 16, or 24 using A high
// [RQ9] C 16, 24, 32 borrowing high bytes
// [RQ10] C samples count mode only at zero
// [RQ11] Prescale bits 1:0 select cascading
// [RQ12] High bytes same index, other bank
// [RQ13] Timers keep running during halt
// [RQ14] Cascade codes give documented lengths
// [RQ15] Capture pin fall latches C 16 bits
// [RQ16] C clock div2 or div8 when 16-bit; code ticks C every clock or every fourth
// [RQ17] Service routine clears flag by writing 0
module cct_top (
  input  wire       clk,
  input  wire       reset,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_q,
  input  wire       shared_edge_pin,
  input  wire       capture_pin,
  input  wire       halt,
  output reg        timer_c_out_pin_q,
  output reg        irq_shared_q,
  output reg        irq_a_q,
  output reg        irq_b_q
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  a_lo_q, a_hi_q, b_lo_q, b_hi_q, c_lo_q, c_hi_q;
  reg  [7:0]  a_pre_q, b_pre_q, mode_q, c_mode_q, c_pre_q;
  reg  [15:0] cap_q;
  reg         cap_d1_q, edge_d1_q, tick_q, c_tog_q;
  reg  [3:0]  cdiv_q;
  wire [31:0] a_cnt, b_cnt, c_cnt;
  wire        a_eoc, b_eoc, c_eoc;
  wire [1:0]  cas = c_pre_q[1:0]; // RQ11
  wire        wr_a = wr & (addr == `CCT_A_PRE);
  wire        wr_b = wr & (addr == `CCT_B_PRE);
  wire        wr_c = wr & (addr == `CCT_C_MODE);

  // Length mask from a byte count
  function [31:0] len_m;
    input [2:0] n;
    begin
      case (n)
        3'd1:    len_m = 32'h0000_00FF;
        3'd2:    len_m = 32'h0000_FFFF;
        3'd3:    len_m = 32'h00FF_FFFF;
        default: len_m = 32'hFFFF_FFFF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Cascade arrangement
  // ----------------------------------------
  reg [2:0]  a_n, b_n, c_n;
  reg [31:0] a_rel, b_rel, c_rel;
  always @* begin
    case (cas) // RQ14
      `CCT_CAS_32:  begin a_n = 3'd1; b_n = 3'd1; c_n = 3'd4; end
      `CCT_CAS_16:  begin a_n = 3'd2; b_n = 3'd2; c_n = 3'd2; end
      `CCT_CAS_B24: begin a_n = 3'd1; b_n = 3'd3; c_n = 3'd2; end
      default:      begin a_n = 3'd1; b_n = 3'd2; c_n = 3'd3; end
    endcase
    // Reload images with borrowed high bytes
    a_rel = {16'h0000, a_hi_q, a_lo_q}; // RQ7
    b_rel = {8'h00, a_hi_q, b_hi_q, b_lo_q}; // RQ8
    if (cas == `CCT_CAS_C24)
      c_rel = {8'h00, a_hi_q, c_hi_q, c_lo_q}; // RQ9
    else
      c_rel = {a_hi_q, b_hi_q, c_hi_q, c_lo_q}; // RQ9
  end

  // Timer C clock: every clock, or every fourth only when 16-bit
  wire c_slow = c_mode_q[`CCT_SLOW_BIT] & (c_n == 3'd2); // RQ16
  wire c_tick = (cdiv_q == 4'h0);

  // ----------------------------------------
  // Channels (keep running regardless of halt)
  // ----------------------------------------
  cct_chan u_a (
    .clk(clk), .reset(reset), .tick(tick_q), .pre_div(a_pre_q[7:2]),
    .run(a_pre_q[`CCT_RUN_BIT]), .cont(mode_q[`CCT_CONT_BIT]),
    .load(wr_a & wdata[`CCT_LOAD_BIT]), .reload(a_rel), .len_mask(len_m(a_n)),
    .count_q(a_cnt), .eoc_q(a_eoc)
  ); // RQ13
  cct_chan u_b (
    .clk(clk), .reset(reset), .tick(tick_q), .pre_div(b_pre_q[7:2]),
    .run(b_pre_q[`CCT_RUN_BIT]), .cont(b_pre_q[`CCT_LOAD_BIT]),
    .load(wr_b & wdata[`CCT_LOAD_BIT]), .reload(b_rel), .len_mask(len_m(b_n)),
    .count_q(b_cnt), .eoc_q(b_eoc)
  );
  cct_chan u_c (
    .clk(clk), .reset(reset), .tick(c_tick), .pre_div({2'b00, c_pre_q[5:2]}),
    .run(c_mode_q[`CCT_RUN_BIT]), .cont(c_mode_q[`CCT_CONT_BIT]),
    .load(wr_c & wdata[`CCT_LOAD_BIT]), .reload(c_rel), .len_mask(len_m(c_n)),
    .count_q(c_cnt), .eoc_q(c_eoc)
  ); // RQ1 RQ10

  // ----------------------------------------
  // Tick dividers
  // ----------------------------------------
  // A and B tick every second clock, C every clock or every fourth
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_q <= 1'b0;
      cdiv_q <= `CCT_DIV_FAST;
    end else begin
      tick_q <= ~tick_q;
      cdiv_q <= c_tick ? (c_slow ? `CCT_DIV_SLOW : `CCT_DIV_FAST) : cdiv_q - 4'h1; // RQ16
    end
  end

  // ----------------------------------------
  // Counter bytes and prescalers
  // ----------------------------------------
  // Low and high count bytes, high bytes in the second bank
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      a_lo_q <= 8'h00;
      a_hi_q <= 8'h00;
      b_lo_q <= 8'h00;
      b_hi_q <= 8'h00;
      c_lo_q <= 8'h00;
      c_hi_q <= 8'h00;
    end else if (wr) begin
      case (addr)
        `CCT_A_CNT_LO: a_lo_q <= wdata;
        `CCT_A_CNT_HI: a_hi_q <= wdata; // RQ12
        `CCT_B_CNT_LO: b_lo_q <= wdata;
        `CCT_B_CNT_HI: b_hi_q <= wdata; // RQ12
        `CCT_C_CNT_HI: c_hi_q <= wdata;
        `CCT_C_CNT_LO: c_lo_q <= wdata;
        default: ;
      endcase
    end
  end

  // Prescale and mode registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      a_pre_q <= 8'h00;
      b_pre_q <= 8'h00;
      mode_q  <= `CCT_MODE_RST;
      c_pre_q <= `CCT_CPRE_RST; // RQ5
    end else if (wr) begin
      case (addr)
        `CCT_A_PRE: a_pre_q <= wdata;
        `CCT_B_PRE: b_pre_q <= wdata;
        `CCT_MODE:  mode_q  <= wdata;
        `CCT_C_PRE: c_pre_q <= wdata; // RQ11
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Timer C mode register and end-of-count flag
  // ----------------------------------------
  // Control bits follow writes; flag set by hardware, set wins
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      c_mode_q <= `CCT_MODE_RST; // RQ5
    end else begin
      if (wr_c)
        c_mode_q[6:0] <= wdata[6:0];
      if (c_eoc)
        c_mode_q[`CCT_EOC_BIT] <= 1'b1; // RQ4
      else if (wr_c & ~wdata[`CCT_EOC_BIT])
        c_mode_q[`CCT_EOC_BIT] <= 1'b0; // RQ4
    end
  end

  // ----------------------------------------
  // Capture register
  // ----------------------------------------
  // Every fall of the capture pin latches the low 16 bits of C
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_d1_q <= 1'b1;
      cap_q    <= 16'h0000;
    end else begin
      cap_d1_q <= capture_pin;
      if (cap_d1_q & ~capture_pin)
        cap_q <= c_cnt[15:0]; // RQ15
    end
  end

  // ----------------------------------------
  // Timer C output pin
  // ----------------------------------------
  // Toggles at each end of count, shown only while enabled
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      c_tog_q           <= 1'b0;
      timer_c_out_pin_q <= 1'b0;
    end else begin
      if (c_eoc)
        c_tog_q <= ~c_tog_q;
      timer_c_out_pin_q <= c_mode_q[`CCT_OUTEN_BIT] & c_tog_q; // RQ2
    end
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // Shared line merges edge pin fall and enabled timer C end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_d1_q    <= 1'b1;
      irq_shared_q <= 1'b0;
      irq_a_q      <= 1'b0;
      irq_b_q      <= 1'b0;
    end else begin
      edge_d1_q    <= shared_edge_pin;
      irq_shared_q <= (edge_d1_q & ~shared_edge_pin) |
                      (c_eoc & c_mode_q[`CCT_OUTEN_BIT]); // RQ3
      irq_a_q      <= a_eoc;
      irq_b_q      <= b_eoc;
    end
  end

  // ----------------------------------------
  // Read port, data one cycle after strobe
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        `CCT_A_CNT_LO: rdata_q <= a_cnt[7:0];
        `CCT_A_CNT_HI: rdata_q <= (a_n == 3'd2) ? a_cnt[15:8] :
                                  (b_n == 3'd3) ? b_cnt[23:16] :
                                  (c_n == 3'd4) ? c_cnt[31:24] : c_cnt[23:16];
        `CCT_B_CNT_LO: rdata_q <= b_cnt[7:0];
        `CCT_B_CNT_HI: rdata_q <= (c_n == 3'd4) ? c_cnt[23:16] : b_cnt[15:8];
        `CCT_MODE:     rdata_q <= mode_q;
        `CCT_C_MODE:   rdata_q <= c_mode_q;
        `CCT_C_PRE:    rdata_q <= c_pre_q; // RQ11
        `CCT_C_CAP_HI: rdata_q <= cap_q[15:8];
        `CCT_C_CAP_LO: rdata_q <= cap_q[7:0];
        `CCT_C_CNT_HI: rdata_q <= c_cnt[15:8];
        `CCT_C_CNT_LO: rdata_q <= c_cnt[7:0];
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
endmodule // cct_top

// ===== sim/cct_asserts.sv
`timescale 1ns/100ps
// ----
// Port checker
// ----
module cct_asserts (
  input wire       clk,
  input wire       reset,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_q,
  input wire       shared_edge_pin,
  input wire       timer_c_out_pin_q,
  input wire       irq_shared_q,
  input wire       irq_a_q,
  input wire       irq_b_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  reg        en_q;
  reg        flag_q;
  reg        rd9_q;
  wire [5:0] wlo = wdata[5:0];
  // Output enable as written, flag once seen set
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      en_q <= 1'b0;
      flag_q <= 1'b0;
      rd9_q <= 1'b0;
    end else begin
      rd9_q <= rd && addr == 4'h9;
      if (wr && addr == 4'h9)
        en_q <= wdata[3];
      if (wr && addr == 4'h9 && !wdata[7])
        flag_q <= 1'b0;
      else if (rd9_q && rdata_q[7])
        flag_q <= 1'b1;
    end
  end
  sequence s_mode_rd;
    rd && addr == 4'h9;
  endsequence
  sequence s_pre_wr_rd;
    (wr && addr == 4'hB) ##1 (rd && addr == 4'hB);
  endsequence
  property p_unmapped;
    rd && addr >= 4'h5 && addr <= 4'h7 |=> rdata_q == 8'h00;
  endproperty
  property p_pre_rb;
    s_pre_wr_rd |=> rdata_q[5:0] == $past(wlo, 2);
  endproperty
  property p_out_off;
    !en_q && !$past(en_q) |-> !timer_c_out_pin_q;
  endproperty
  property p_quiet;
    (!en_q && shared_edge_pin) [*4] |-> !irq_shared_q;
  endproperty
  property p_edge;
    $fell(shared_edge_pin) |-> ##[1:3] irq_shared_q;
  endproperty
  property p_sticky;
    s_mode_rd ##0 flag_q |=> rdata_q[7];
  endproperty
  property p_a_pulse;
    irq_a_q |=> !irq_a_q;
  endproperty
  property p_b_pulse;
    $rose(irq_b_q) |=> $fell(irq_b_q);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_pre_rb: assert property (p_pre_rb) else $error("prescale readback wrong");
  a_out_off: assert property (p_out_off) else $error("pin driven while off");
  a_quiet: assert property (p_quiet) else $error("shared request while off");
  a_edge: assert property (p_edge) else $error("edge request missing");
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");
  a_a_pulse: assert property (p_a_pulse) else $error("timer a request long");
  a_b_pulse: assert property (p_b_pulse) else $error("timer b request long");
endmodule // cct_asserts

bind cct_top cct_asserts u_chk (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata_q,
  .shared_edge_pin, .timer_c_out_pin_q, .irq_shared_q, .irq_a_q, .irq_b_q);

// ===== sim/cct_pins.sv
`timescale 1ns/100ps
// ----
// Edge and capture pin source
// ----
module cct_pins (
  input  wire clk,
  input  wire fire_edge,
  input  wire fire_cap,
  output wire shared_edge_pin,
  output wire capture_pin
);
  integer e_n = 0;
  integer c_n = 0;
  // Each request pulls its pin low three cycles
  always @(posedge clk) begin
    e_n <= fire_edge ? 3 : (e_n > 0 ? e_n - 1 : 0);
    c_n <= fire_cap ? 3 : (c_n > 0 ? c_n - 1 : 0);
  end
  assign shared_edge_pin = (e_n == 0);
  assign capture_pin = (c_n == 0);
endmodule // cct_pins

// ===== sim/test_cascadable_counter_timers.sv
`timescale 1ns/100ps
module test_cascadable_counter_timers;
  reg        clk = 0, reset = 1, wr = 0, rd = 0, halt = 0, fe = 0, fc = 0, h;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00, v, v2;
  wire [7:0] rdata_q;
  wire       sp, cp, opin, irq_s, irq_a, irq_b;
  wire [2:0] ev = {irq_s, irq_b, irq_a};
  integer    err_total = 0, checked = 0, cyc = 0, t;
  initial forever #5 clk = ~clk;
  cct_top DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .shared_edge_pin(sp), .capture_pin(cp), .halt(halt),
    .timer_c_out_pin_q(opin), .irq_shared_q(irq_s), .irq_a_q(irq_a), .irq_b_q(irq_b));
  cct_pins u_pins (.clk(clk), .fire_edge(fe), .fire_cap(fc), .shared_edge_pin(sp),
    .capture_pin(cp));
  // ----
  // Tasks
  // ----
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr_r(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_r(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata_q;
    end
  endtask
  // Write then read back the same index with no gap
  task wr_rd(input [3:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata_q;
    end
  endtask
  // Cycles until request s, lim if none
  task wait_ev(input integer s, input integer lim, output integer n);
    begin
      n = 0;
      // Let a request still standing from the last wait pass first
      while (ev[s] === 1'b1) begin
        @(posedge clk);
        #1;
      end
      while (n < lim && ev[s] !== 1'b1) begin
        @(posedge clk);
        #1 n = n + 1;
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd_r(4'h9, v); chk(v, 8'h00);
    rd_r(4'hB, v); chk(v, 8'h00);
    wr_r(4'h5, 8'hA5);
    rd_r(4'h5, v); chk(v, 8'h00);
    // A short in 8-bit, long in 16-bit
    wr_r(4'h8, 8'h01);
    wr_r(4'h0, 8'h04);
    wr_r(4'h1, 8'h03);
    wait_ev(0, 60, t); chk(t < 60, 1);
    wr_rd(4'hB, 8'h01, v); chk(v, 8'h01);
    wr_r(4'h1, 8'h03);
    wait_ev(0, 1200, t); chk(t > 300 && t < 1200, 1);
    // B short in 16-bit, borrows A high in 24-bit
    wr_r(4'hA, 8'h00);
    wr_r(4'h2, 8'h04);
    wr_r(4'hB, 8'h03);
    wr_r(4'h3, 8'h03);
    wait_ev(1, 60, t); chk(t < 60, 1);
    wr_r(4'h3, 8'h00);
    wr_r(4'hB, 8'h02);
    wr_r(4'h3, 8'h03);
    wait_ev(1, 400, t); chk(t == 400, 1);
    wr_r(4'h3, 8'h00);
    // C 16-bit single pass with output, in halt
    wr_r(4'hB, 8'h01);
    wr_r(4'hE, 8'h00);
    wr_r(4'hF, 8'h08);
    halt <= 1'b1;
    wr_r(4'h9, 8'h0B);
    wait_ev(2, 60, t); chk(t < 60, 1);
    rd_r(4'h9, v); chk(v[7], 1);
    wait_ev(2, 100, t); chk(t, 100);
    wr_r(4'h9, 8'h80);
    rd_r(4'h9, v); chk(v[7], 1);
    wr_r(4'h9, 8'h00);
    rd_r(4'h9, v); chk(v[7], 0);
    // Switch to continuous in mid-count
    wr_r(4'h9, 8'h0B);
    wr_r(4'h9, 8'h0E);
    wait_ev(2, 60, t);
    wait_ev(2, 60, t); chk(t < 20, 1);
    h = 0;
    repeat (40) begin
      @(posedge clk);
      #1 if (opin === 1'b1) h = 1;
    end
    chk(h, 1);
    wr_r(4'h9, 8'h1F);
    wait_ev(2, 60, t);
    wait_ev(2, 60, t); chk(t >= 24 && t < 60, 1);
    // Capture holds while C runs
    @(posedge clk) fc <= 1'b1;
    @(posedge clk) fc <= 1'b0;
    repeat (6) @(posedge clk);
    rd_r(4'hD, v); chk(v <= 8'h08, 1);
    wr_r(4'hD, 8'h5A);
    repeat (7) @(posedge clk);
    rd_r(4'hD, v2); chk(v2, v);
    rd_r(4'hC, v2); chk(v2, 8'h00);
    // Edge pin request with timer C off
    wr_r(4'h9, 8'h00);
    halt <= 1'b0;
    repeat (4) @(posedge clk);
    @(posedge clk) fe <= 1'b1;
    @(posedge clk) fe <= 1'b0;
    wait_ev(2, 10, t); chk(t < 10, 1);
    summarize;
  end
endmodule // test_cascadable_counter_timers
